// [hdl/sfcs_pkg.sv]
// shared constants, carriers and helpers of the serial port format and clock-select block
// assumes a single 25 MHz system clock; no register bus, control bits arrive as ports
package sfcs_pkg;

  // ************************************************************
  // mode register field positions
  // ************************************************************
  localparam int MODE_SYNC_BIT = 7;
  localparam int MODE_CHR_BIT = 6;
  localparam int MODE_PE_BIT = 5;
  localparam int MODE_ODD_BIT = 4;
  localparam int MODE_STOP_BIT = 3;
  localparam int MODE_MP_BIT = 2;

  // ************************************************************
  // timing and sizes
  // ************************************************************
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] SAMPLE_PHASE = 4'h7;
  localparam logic [3:0] LAST_PHASE = 4'(OVERSAMPLE - 1);
  localparam int RX_FIFO_DEPTH = 8;
  localparam logic [7:0] BRG_RESET = 8'h00;
  localparam logic [2:0] PIN_RESET = 3'h7;

  // ************************************************************
  // carriers and states
  // ************************************************************
  typedef struct packed {
    logic mpb;
    logic [7:0] data;
  } sfcs_tx_word_t;

  typedef struct packed {
    logic mpb;
    logic parity_err;
    logic framing_err;
    logic [7:0] data;
  } sfcs_rx_word_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_DATA = 3'b010,
    ST_EXTRA = 3'b011,
    ST_STOP = 3'b100
  } sfcs_state_t;

  // data bits per character; clocked synchronous mode is always eight
  function automatic logic [3:0] sfcs_data_bits(input logic [7:0] mode);
    sfcs_data_bits = (!mode[MODE_SYNC_BIT] && mode[MODE_CHR_BIT]) ? 4'h7 : 4'h8;
  endfunction : sfcs_data_bits

  // parity over the used data bits, even unless odd is chosen
  function automatic logic sfcs_parity(input logic [7:0] data, input logic [7:0] mode);
    logic [7:0] used;
    used = mode[MODE_CHR_BIT] ? {1'b0, data[6:0]} : data;
    sfcs_parity = (^used) ^ mode[MODE_ODD_BIT];
  endfunction : sfcs_parity

endpackage : sfcs_pkg

// [hdl/sfcs_top.sv]
// serial port: mode/format/clock selection, async and clocked framing, receive sampling
// assumes unsynchronised rxd and sck pins, and software that drops both enables
// before it changes mode, format or clock selection
//
// What this block does
// - clocked synchronous mode: eight data bits, no parity, mp bit or stop bits
// - clocked synchronous receive detects only overrun; other error flags stay clear
// - synchronous internal clock: time from baud generator, drive serial clock out
// - synchronous external clock: shift on the far clock, baud generator idle
// - mode bits select sync, 7/8 bits, parity, stop length, multiprocessor format
// - async, clock bits clear: clock pin unused; bit 0 only: bit-rate clock out
// - async with clock bit 1: pin supplies sixteen times the bit rate
// - synchronous: clock bit 1 clear drives the clock, set accepts it
// - async character framed by start and stop, resynchronised per character
// - transmitter and receiver run independently for full duplex
// - holding stage before the transmit shifter and buffer after the receive shifter allow back-to-back characters
// - async line rests high between characters
// - receiver starts a character when the idle line falls low
// - order: low start, data lsb first, optional parity, high stop bits
// - receiver aligns to start edge, samples on eighth of sixteen pulses
// - async offers twelve formats from length, parity/mp and stop length
`timescale 1ns/1ps

// ************************************************************
// receive buffer
// ************************************************************
// depth must be a power of two; full and empty come from the wrap bit
module sfcs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic push, pop;

  // full when pointers differ only in the wrap bit
  assign in_ready_o = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_valid_o = (wr_ptr != rd_ptr);
  assign out_data_o = mem[rd_ptr[AW-1:0]];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // pointer advance
  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // storage carries no reset, only pointers matter
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end
endmodule : sfcs_fifo

// ************************************************************
// serial port core
// ************************************************************
module sfcs_top import sfcs_pkg::*; #(
  parameter int FIFO_DEPTH = RX_FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] mode_register_i,
  input wire logic clock_source_select_i,
  input wire logic clock_output_enable_i,
  input wire logic transmit_enable_bit_i,
  input wire logic receive_enable_bit_i,
  input wire logic [7:0] brg_divisor_i,
  input wire sfcs_tx_word_t tx_word_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  output logic tx_end_o,
  output sfcs_rx_word_t rx_word_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  output logic overrun_flag_o,
  input wire logic overrun_clear_i,
  output logic txd_o,
  input wire logic rxd_i,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_o
);
  logic sync_mode, ext_clk, extra_on, tick16, sck_run, tx_bit_end, sync_take;
  logic [3:0] nbits;
  logic [2:0] rxd_pipe, sck_pipe, next_rxd_pipe, next_sck_pipe;
  logic rxd_clean, sck_clean, next_rxd_clean, next_sck_clean, sck_rise, sck_fall, rxd_fall;
  logic [7:0] brg_cnt, next_brg_cnt;
  logic [3:0] clk_phase, next_clk_phase;
  logic sck_drv, next_sck_drv;
  sfcs_state_t tx_state, next_tx_state, rx_state, next_rx_state;
  logic [7:0] tx_shift, next_tx_shift, rx_shift, next_rx_shift;
  logic [3:0] tx_bitcnt, next_tx_bitcnt, rx_bitcnt, next_rx_bitcnt, rx_cnt, next_rx_cnt;
  logic tx_extra, next_tx_extra, tx_second, next_tx_second, txd, next_txd, tx_done;
  sfcs_tx_word_t hold, next_hold;
  logic hold_full, next_hold_full;
  logic rx_extra, next_rx_extra, rx_push, next_rx_push, rx_sample, fifo_in_ready;
  sfcs_rx_word_t rx_word, next_rx_word;
  logic overrun, next_overrun;

  // format decode from the mode bits
  assign sync_mode = mode_register_i[MODE_SYNC_BIT];
  assign nbits = sfcs_data_bits(mode_register_i);
  assign extra_on = !sync_mode && (mode_register_i[MODE_PE_BIT] || mode_register_i[MODE_MP_BIT]);
  // bit 1 set wins, bit 0 then has no say
  assign ext_clk = clock_source_select_i;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  // a level is accepted once the 2nd and 3rd stages agree
  always_comb begin
    next_rxd_pipe = {rxd_pipe[1:0], rxd_i};
    next_sck_pipe = {sck_pipe[1:0], sck_i};
    next_rxd_clean = (rxd_pipe[1] == rxd_pipe[2]) ? rxd_pipe[2] : rxd_clean;
    next_sck_clean = (sck_pipe[1] == sck_pipe[2]) ? sck_pipe[2] : sck_clean;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rxd_pipe <= PIN_RESET;
      sck_pipe <= PIN_RESET;
      rxd_clean <= 1'b1;
      sck_clean <= 1'b1;
    end else begin
      rxd_pipe <= next_rxd_pipe;
      sck_pipe <= next_sck_pipe;
      rxd_clean <= next_rxd_clean;
      sck_clean <= next_sck_clean;
    end
  end

  assign sck_rise = next_sck_clean && !sck_clean;
  assign sck_fall = !next_sck_clean && sck_clean;
  // start needs a real falling edge, so a low stop bit cannot restart the receiver
  assign rxd_fall = !next_rxd_clean && rxd_clean;

  // ************************************************************
  // clock sources
  // ************************************************************
  // baud generator held at zero while the pin clock is used
  always_comb begin
    next_brg_cnt = brg_cnt + 8'h01;
    if (ext_clk || brg_cnt >= brg_divisor_i) begin
      next_brg_cnt = BRG_RESET;
    end
  end

  // sixteen-times clock from the pin when external
  assign tick16 = ext_clk ? sck_rise : (brg_cnt >= brg_divisor_i);
  // synchronous clock runs only while there is work, else it idles high
  assign sck_run = (tx_state != ST_IDLE) || hold_full || receive_enable_bit_i;

  // bit phase; sck rises at phase 8, the middle of each transmit bit
  always_comb begin
    next_clk_phase = tick16 ? clk_phase + 4'h1 : clk_phase;
    if (sync_mode && !sck_run) begin
      next_clk_phase = LAST_PHASE;
    end
    // back to idle high as the last bit ends, else a stray short pulse reaches the pin
    next_sck_drv = next_clk_phase[3] || (sync_mode && next_tx_state == ST_IDLE && !next_hold_full &&
      !receive_enable_bit_i);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      brg_cnt <= BRG_RESET;
      clk_phase <= LAST_PHASE;
      sck_drv <= 1'b1;
    end else begin
      brg_cnt <= next_brg_cnt;
      clk_phase <= next_clk_phase;
      sck_drv <= next_sck_drv;
    end
  end

  // drive the pin for sync internal or async bit-rate output
  assign sck_oe_o = !ext_clk && (sync_mode || clock_output_enable_i);
  assign sck_o = sck_drv;

  // synchronous external: shift on far falling, sample on far rising
  assign tx_bit_end = (sync_mode && ext_clk) ? sck_fall : (tick16 && clk_phase == LAST_PHASE);
  assign sync_take = ext_clk ? sck_rise : (tick16 && clk_phase == SAMPLE_PHASE && sck_run);

  // ************************************************************
  // transmitter
  // ************************************************************
  // transmit state shares only the clock phase with receive
  always_comb begin
    next_tx_state = tx_state;
    next_tx_shift = tx_shift;
    next_tx_extra = tx_extra;
    next_tx_bitcnt = tx_bitcnt;
    next_tx_second = tx_second;
    next_hold = hold;
    next_hold_full = hold_full;
    next_txd = txd;
    tx_done = 1'b0;
    if (tx_bit_end) begin
      // start, data lsb first, parity or mp bit, stop
      unique case (tx_state)
        ST_IDLE: tx_done = 1'b1;
        ST_START: begin
          next_tx_state = ST_DATA;
          next_txd = tx_shift[0];
        end
        ST_DATA: begin
          next_tx_shift = tx_shift >> 1;
          next_tx_bitcnt = tx_bitcnt + 4'h1;
          next_txd = tx_shift[1];
          // synchronous character ends after its eight data bits
          if (tx_bitcnt == nbits - 4'h1) begin
            if (sync_mode) begin
              tx_done = 1'b1;
            end else if (extra_on) begin
              next_tx_state = ST_EXTRA;
              next_txd = tx_extra;
            end else begin
              next_tx_state = ST_STOP;
              next_txd = 1'b1;
              next_tx_second = 1'b0;
            end
          end
        end
        ST_EXTRA: begin
          next_tx_state = ST_STOP;
          next_txd = 1'b1;
          next_tx_second = 1'b0;
        end
        ST_STOP: begin
          if (mode_register_i[MODE_STOP_BIT] && !tx_second) begin
            next_tx_second = 1'b1;
          end else begin
            tx_done = 1'b1;
          end
        end
        default: next_tx_state = ST_IDLE;
      endcase
    end
    // rest at mark, or chain straight into the held character
    if (tx_done) begin
      next_tx_state = ST_IDLE;
      next_txd = 1'b1;
      if (hold_full) begin
        next_tx_shift = hold.data;
        next_tx_bitcnt = 4'h0;
        next_hold_full = 1'b0;
        next_tx_extra = mode_register_i[MODE_MP_BIT] ? hold.mpb : sfcs_parity(hold.data, mode_register_i);
        next_tx_state = sync_mode ? ST_DATA : ST_START;
        next_txd = sync_mode ? hold.data[0] : 1'b0;
      end
    end
    // holding stage accepts the next character while shifting
    if (tx_valid_i && tx_ready_o) begin
      next_hold = tx_word_i;
      next_hold_full = 1'b1;
    end
    // disabled transmitter returns to mark and empties the holding stage
    if (!transmit_enable_bit_i) begin
      next_tx_state = ST_IDLE;
      next_hold_full = 1'b0;
      next_txd = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tx_state <= ST_IDLE;
      tx_shift <= 8'h00;
      tx_extra <= 1'b0;
      tx_bitcnt <= 4'h0;
      tx_second <= 1'b0;
      hold <= '0;
      hold_full <= 1'b0;
      txd <= 1'b1;
    end else begin
      tx_state <= next_tx_state;
      tx_shift <= next_tx_shift;
      tx_extra <= next_tx_extra;
      tx_bitcnt <= next_tx_bitcnt;
      tx_second <= next_tx_second;
      hold <= next_hold;
      hold_full <= next_hold_full;
      txd <= next_txd;
    end
  end

  assign tx_ready_o = transmit_enable_bit_i && !hold_full;
  assign tx_end_o = transmit_enable_bit_i && !hold_full && (tx_state == ST_IDLE);
  assign txd_o = txd;

  // ************************************************************
  // receiver
  // ************************************************************
  always_comb begin
    next_rx_state = rx_state;
    next_rx_shift = rx_shift;
    next_rx_bitcnt = rx_bitcnt;
    next_rx_extra = rx_extra;
    next_rx_word = rx_word;
    next_rx_push = 1'b0;
    next_rx_cnt = tick16 ? rx_cnt + 4'h1 : rx_cnt;
    // eighth oversample pulse after the start edge
    rx_sample = sync_mode ? sync_take : (tick16 && rx_cnt == SAMPLE_PHASE);
    unique case (rx_state)
      // falling line marks a start bit
      ST_IDLE: begin
        next_rx_bitcnt = 4'h0;
        if (sync_mode) begin
          next_rx_state = ST_DATA;
        end else if (rxd_fall) begin
          next_rx_state = ST_START;
          next_rx_cnt = 4'h0;
        end
      end
      // a start bit gone high by mid-bit was a glitch
      ST_START: if (rx_sample) begin
        next_rx_state = rxd_clean ? ST_IDLE : ST_DATA;
      end
      ST_DATA: if (rx_sample) begin
        next_rx_shift = {rxd_clean, rx_shift[7:1]};
        next_rx_bitcnt = rx_bitcnt + 4'h1;
        if (rx_bitcnt == nbits - 4'h1) begin
          // synchronous word carries no parity or framing error
          if (sync_mode) begin
            next_rx_push = 1'b1;
            next_rx_bitcnt = 4'h0;
            next_rx_word = '{mpb: 1'b0, parity_err: 1'b0, framing_err: 1'b0, data: next_rx_shift};
          end else begin
            next_rx_state = extra_on ? ST_EXTRA : ST_STOP;
          end
        end
      end
      ST_EXTRA: if (rx_sample) begin
        next_rx_extra = rxd_clean;
        next_rx_state = ST_STOP;
      end
      // only the first stop bit is checked, then rearm per character
      ST_STOP: if (rx_sample) begin
        next_rx_push = 1'b1;
        next_rx_state = ST_IDLE;
        next_rx_word.data = mode_register_i[MODE_CHR_BIT] ? {1'b0, rx_shift[7:1]} : rx_shift;
        next_rx_word.framing_err = !rxd_clean;
        next_rx_word.mpb = mode_register_i[MODE_MP_BIT] && rx_extra;
        next_rx_word.parity_err = mode_register_i[MODE_PE_BIT] && !mode_register_i[MODE_MP_BIT] &&
          (sfcs_parity(next_rx_word.data, mode_register_i) != rx_extra);
      end
      default: next_rx_state = ST_IDLE;
    endcase
    // enable dropped before any format change; flags and buffer kept
    if (!receive_enable_bit_i) begin
      next_rx_state = ST_IDLE;
      next_rx_push = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rx_state <= ST_IDLE;
      rx_shift <= 8'h00;
      rx_bitcnt <= 4'h0;
      rx_cnt <= 4'h0;
      rx_extra <= 1'b0;
      rx_word <= '0;
      rx_push <= 1'b0;
    end else begin
      rx_state <= next_rx_state;
      rx_shift <= next_rx_shift;
      rx_bitcnt <= next_rx_bitcnt;
      rx_cnt <= next_rx_cnt;
      rx_extra <= next_rx_extra;
      rx_word <= next_rx_word;
      rx_push <= next_rx_push;
    end
  end

  // receive side holding stage is this buffer
  sfcs_fifo #(
    .WIDTH($bits(sfcs_rx_word_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .in_data_i(rx_word),
    .in_valid_i(rx_push),
    .in_ready_o(fifo_in_ready),
    .out_data_o(rx_word_o),
    .out_valid_o(rx_valid_o),
    .out_ready_i(rx_ready_i)
  );

  // overrun: character lost to a full buffer; a new one beats the clear
  always_comb begin
    next_overrun = (overrun && !overrun_clear_i) || (rx_push && !fifo_in_ready);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      overrun <= 1'b0;
    end else begin
      overrun <= next_overrun;
    end
  end

  assign overrun_flag_o = overrun;

  // ************************************************************
  // checks
  // ************************************************************
  chk_sync_no_errors:
  assert property (@(posedge clk_i) disable iff (reset_i)
    rx_push && sync_mode |-> !rx_word.parity_err && !rx_word.framing_err)
  else $error("error flag in clocked synchronous word");

  chk_overrun_set:
  assert property (@(posedge clk_i) disable iff (reset_i)
    rx_push && !fifo_in_ready |=> overrun_flag_o)
  else $error("overrun not flagged on full buffer");

  chk_idle_mark:
  assert property (@(posedge clk_i) disable iff (reset_i)
    tx_state == ST_IDLE |-> txd_o)
  else $error("line not at mark while idle");

  chk_start_low:
  assert property (@(posedge clk_i) disable iff (reset_i)
    tx_state == ST_START |-> !txd_o && !sync_mode)
  else $error("start bit not low");

  chk_pin_unused:
  assert property (@(posedge clk_i) disable iff (reset_i)
    !sync_mode && !clock_source_select_i && !clock_output_enable_i |-> !sck_oe_o)
  else $error("clock pin driven when unused");

  chk_ext_brg_idle:
  assert property (@(posedge clk_i) disable iff (reset_i)
    clock_source_select_i ##1 clock_source_select_i |-> brg_cnt == 8'h00 && !sck_oe_o)
  else $error("baud generator or pin driver active on external clock");

  chk_sync_drive:
  assert property (@(posedge clk_i) disable iff (reset_i)
    sync_mode && !clock_source_select_i |-> sck_oe_o)
  else $error("synchronous internal clock not driven");

  chk_start_sample:
  assert property (@(posedge clk_i) disable iff (reset_i)
    receive_enable_bit_i && !sync_mode && rx_state == ST_START && tick16 && rx_cnt == SAMPLE_PHASE
      && !rxd_clean |=> rx_state == ST_DATA)
  else $error("start bit not taken at the eighth pulse");

  chk_hold_load:
  assert property (@(posedge clk_i) disable iff (reset_i)
    tx_valid_i && tx_ready_o |=> hold_full && !tx_ready_o)
  else $error("holding stage did not take the character");

  chk_data_count:
  assert property (@(posedge clk_i) disable iff (reset_i)
    tx_state == ST_DATA |-> tx_bitcnt < nbits)
  else $error("more data bits than the format allows");

  chk_rx_rearm:
  assert property (@(posedge clk_i) disable iff (reset_i)
    receive_enable_bit_i && rx_state == ST_STOP && rx_sample |=> rx_state == ST_IDLE && rx_push)
  else $error("receiver did not rearm after stop bit");

  chk_sync_clock_idle:
  assert property (@(posedge clk_i) disable iff (reset_i)
    sync_mode && transmit_enable_bit_i && !receive_enable_bit_i && !$past(receive_enable_bit_i)
      && tx_state == ST_IDLE && !hold_full |-> sck_o)
  else $error("synchronous clock not idle high between characters");
endmodule : sfcs_top

// [tb/sfcs_far_end.sv]
// far-end serial party: a remote async sender and a listener
// assumes bit time given in system clocks, line pulled up to mark
`timescale 1ns/1ps
module sfcs_far_end (
  input wire logic clk_i,
  input wire logic txd_i,
  output logic rxd_o,
  input wire logic listen_i,
  input var int len_i,
  input var int bitclk_i
);
  logic [11:0] got[$];
  logic [11:0] fr;
  int i;
  // ************
  // listener
  // ************
  // resync per character
  always begin
    @(negedge txd_i);
    if (listen_i) begin
      fr = '1;
      repeat (bitclk_i / 2) @(posedge clk_i);
      // last sample mid stop so a back-to-back start is not missed
      for (i = 0; i < len_i; i++) begin
        fr[i] = txd_i;
        if (i < len_i - 1) repeat (bitclk_i) @(posedge clk_i);
      end
      got.push_back(fr);
    end
  end
  // ************
  // sender
  // ************
  // mark after each frame
  task automatic send(input logic [11:0] f, input int n);
    for (int b = 0; b < n + 1; b++) begin
      rxd_o = (b < n) ? f[b] : 1'b1;
      repeat (bitclk_i) @(posedge clk_i);
      #1;
    end
  endtask : send
  // line idles at mark
  initial rxd_o = 1'b1;
endmodule : sfcs_far_end

// [tb/sfcs_top_tb.sv]
// self-checking bench of the serial port core
// assumes the far-end model on the serial pins, sck_i held high
`timescale 1ns/1ps
module sfcs_top_tb import sfcs_pkg::*;;
  logic clk_i, reset_i, css, coe, te, re, txv, rxr, ovc, sck_in, listen, mb;
  logic tx_ready, tx_end, rx_valid, ovf, txd, rxd, sck_o, sck_oe;
  logic [7:0] mode, div, d0, d1, d2, sb;
  logic [7:0] dq[9];
  logic [11:0] e0, e1, e2;
  sfcs_tx_word_t txw;
  sfcs_rx_word_t rxw, w;
  int fail_count, checked, cyc, flen, n1, bitclk, f, j, k;
  sfcs_top #(.FIFO_DEPTH(8)) sfcs_top_inst (.clk_i(clk_i), .reset_i(reset_i),
    .mode_register_i(mode), .clock_source_select_i(css), .clock_output_enable_i(coe),
    .transmit_enable_bit_i(te), .receive_enable_bit_i(re), .brg_divisor_i(div),
    .tx_word_i(txw), .tx_valid_i(txv), .tx_ready_o(tx_ready), .tx_end_o(tx_end),
    .rx_word_o(rxw), .rx_valid_o(rx_valid), .rx_ready_i(rxr), .overrun_flag_o(ovf),
    .overrun_clear_i(ovc), .txd_o(txd), .rxd_i(rxd), .sck_i(sck_in), .sck_o(sck_o),
    .sck_oe_o(sck_oe));
  sfcs_far_end sfcs_far_end_inst (.clk_i(clk_i), .txd_i(txd), .rxd_o(rxd),
    .listen_i(listen), .len_i(flen), .bitclk_i(bitclk));
  // ************
  // helpers
  // ************
  // expected line bits, lsb first, and their count
  function automatic logic [11:0] frame(input logic [7:0] m, input logic [7:0] d,
                                        input logic b, output int n);
    logic [11:0] fb;
    fb = '1;
    fb[0] = 1'b0;
    n = m[6] ? 8 : 9;
    for (int i = 1; i < n; i++) fb[i] = d[i-1];
    if (m[2] || m[5]) begin
      fb[n] = m[2] ? b : ^(d[6:0]) ^ (d[7] & !m[6]) ^ m[4];
      n++;
    end
    n += m[3] ? 2 : 1;
    return fb;
  endfunction : frame
  task automatic chk(input logic [11:0] s, input logic [11:0] e, input string msg);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("Error at %0t: %s seen %h expected %h", $time, msg, s, e);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step
  // offer a word, held until taken
  task automatic put_tx(input logic [7:0] d, input logic b);
    int t;
    t = 0;
    txw = {b, d};
    txv = 1'b1;
    @(posedge clk_i);
    while (tx_ready !== 1'b1 && t < 5000) begin
      @(posedge clk_i);
      t++;
    end
    chk(t < 5000, 1'b1, "tx handshake");
    #1 txv = 1'b0;
    step(1);
  endtask : put_tx
  task automatic pop(output sfcs_rx_word_t o);
    int t;
    t = 0;
    while (rx_valid !== 1'b1 && t < 5000) begin
      step(1);
      t++;
    end
    chk(t < 5000, 1'b1, "rx wait");
    o = rxw;
    rxr = 1'b1;
    step(1);
    rxr = 1'b0;
    step(1);
  endtask : pop
  // enables drop before every mode change
  task automatic set_mode(input logic [7:0] m, input logic t, input logic r);
    te = 1'b0;
    re = 1'b0;
    step(2);
    mode = m;
    step(2);
    te = t;
    re = r;
    step(34);
  endtask : set_mode
  // ************
  // clock, timeout, sequence
  // ************
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // cut a hang short well past the expected run
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      tally_and_finish;
    end
  end
  initial begin
    {reset_i, css, coe, te, re, txv, rxr, ovc, sck_in, listen} = 10'h202;
    mode = 8'h00;
    div = 8'h01;
    txw = '0;
    bitclk = 32;
    flen = 10;
    void'($urandom(32'h7e530f39));
    step(4);
    reset_i = 1'b0;
    chk({txd, sck_o, ovf, rx_valid}, 4'hc, "reset idle");
    for (f = 0; f < 8; f++) begin
      {mode[7], css, coe} = f[2:0];
      step(1);
      chk(sck_oe, !f[1] && (f[2] || f[0]), "sck direction");
    end
    {css, coe} = 2'b00;
    $display("clock select table done");
    listen = 1'b1;
    for (f = 0; f < 12; f++) begin
      set_mode({1'b0, f[3] ? f[1] : f[2], f[3] ? 1'($urandom) : f[1], 1'($urandom), f[0], f[3], 2'b00},
               1'b1, 1'b1);
      {d0, d1, d2, mb} = {8'($urandom), 8'($urandom), 8'($urandom), 1'($urandom)};
      e0 = frame(mode, d0, mb, flen);
      e1 = frame(mode, d1, ~mb, n1);
      e2 = frame(mode, d2, mb, n1);
      fork
        begin
          put_tx(d0, mb);
          put_tx(d1, ~mb);
        end
        sfcs_far_end_inst.send(e2, flen);
      join
      for (k = 0; k < 3000 && sfcs_far_end_inst.got.size() < 2; k++) step(1);
      chk(tx_end, 1'b0, "tx busy in stop bit");
      chk(sfcs_far_end_inst.got.pop_front(), e0, "tx frame");
      chk(sfcs_far_end_inst.got.pop_front(), e1, "back to back frame");
      pop(w);
      chk({w.parity_err, w.framing_err, w.data}, {2'b00, ~mode[6] & d2[7], d2[6:0]}, "rx word");
      chk(w.mpb, mode[2] & mb, "rx mp bit");
      step(16);
      chk(tx_end, 1'b1, "tx end");
      $display("format %0d done", f);
    end
    set_mode(8'h20, 1'b0, 1'b1);
    for (j = 0; j < 9; j++) begin
      dq[j] = 8'($urandom);
      e2 = frame(mode, dq[j], 1'b0, flen);
      if (j == 3) e2[flen-1] = 1'b0;
      if (j == 5) e2[9] = ~e2[9];
      sfcs_far_end_inst.send(e2, flen);
    end
    step(40);
    chk(ovf, 1'b1, "overrun");
    for (j = 0; j < 8; j++) begin
      pop(w);
      chk({w.parity_err, w.framing_err, w.data}, {j == 5, j == 3, dq[j]}, "buffer order");
    end
    chk({rx_valid, tx_ready}, 2'b00, "drained, tx refused while off");
    ovc = 1'b1;
    step(1);
    ovc = 1'b0;
    step(1);
    chk(ovf, 1'b0, "overrun clear");
    $display("buffer and errors done");
    listen = 1'b0;
    set_mode({1'b1, 7'($urandom)}, 1'b1, 1'b0);
    d0 = 8'($urandom);
    fork
      put_tx(d0, 1'b1);
      for (j = 0; j < 8; j++) begin
        @(posedge sck_o);
        sb[j] = txd;
      end
    join
    chk(sb, d0, "sync byte");
    step(64);
    chk({sck_o, sck_oe}, 2'b11, "sync clock idle");
    $display("sync transmit done");
    tally_and_finish;
  end
endmodule : sfcs_top_tb
